// >>> rtl/asr_regs.svh
// Register offsets, reset values, field positions and mux codes of the status and input mux registers
`ifndef ASR_REGS_SVH
`define ASR_REGS_SVH

// Address width of the command port, wide enough for the whole 18-register map
`define ASR_ADDR_W          5
`define ASR_DATA_W          8

// Register offsets
`define ASR_ADDR_STATUS     5'h01
`define ASR_ADDR_INMUX      5'h02

// Reset values
`define ASR_STATUS_RST      8'h80
`define ASR_INMUX_RST       8'h01
`define ASR_POS_SEL_RST     4'h0
`define ASR_NEG_SEL_RST     4'h1

// Status field positions
`define ASR_BIT_POWER_ON    7
`define ASR_BIT_NOT_READY   6
`define ASR_BIT_POS_UPPER   5
`define ASR_BIT_POS_LOWER   4
`define ASR_BIT_NEG_UPPER   3
`define ASR_BIT_NEG_LOWER   2
`define ASR_BIT_REF_THIRD   1
`define ASR_BIT_REF_LOW     0

// Input mux field positions
`define ASR_POS_MSB         7
`define ASR_POS_LSB         4
`define ASR_NEG_MSB         3
`define ASR_NEG_LSB         0

// Input mux codes
`define ASR_CODE_LAST_SHORT 4'h5
`define ASR_CODE_LAST_LONG  4'hB
`define ASR_CODE_COMMON     4'hC

// Channel counts of the two variants
`define ASR_CHANNELS_SHORT  6
`define ASR_CHANNELS_LONG   12

`endif

// >>> rtl/asr_pkg.sv
// Types shared by the status and input mux register block
package asr_pkg;

  // One register command from the serial command decoder
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [4:0] addr;
    logic [7:0] wdata;
  } asr_cmd_t;

  // Status register image, bit 7 first
  typedef struct packed {
    logic power_on_flag;
    logic not_ready;
    logic pos_out_near_upper_rail;
    logic pos_out_near_lower_rail;
    logic neg_out_near_upper_rail;
    logic neg_out_near_lower_rail;
    logic ref_below_third_supply;
    logic ref_below_low_threshold;
  } asr_status_t;

  // Input mux register image
  typedef struct packed {
    logic [3:0] positive_input_select;
    logic [3:0] negative_input_select;
  } asr_inmux_t;

  // Analog monitor levels, raw from the comparators
  typedef struct packed {
    logic startup_busy;
    logic pos_upper;
    logic pos_lower;
    logic neg_upper;
    logic neg_lower;
    logic ref_third;
    logic ref_low;
  } asr_monitor_t;

endpackage

// >>> rtl/asr_pin_sync.sv
// Three-stage synchroniser whose output follows only when the last two stages agree
`timescale 1ns/100ps
module asr_pin_sync #(
  parameter int WIDTH = 7
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_sync_out;

  initial begin
    if (WIDTH < 1) begin
      $error("asr_pin_sync: WIDTH must be at least 1");
    end
  end

  // Stage 1 is read by stage 2 only; the filter looks at stages 2 and 3
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_sync_out[i] = (stage2[i] == stage3[i]) ? stage3[i] : sync_out[i];
    end
  end

  // Chain and filtered output
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1   <= '0;
      stage2   <= '0;
      stage3   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      stage2   <= stage1;
      stage3   <= stage2;
      sync_out <= next_sync_out;
    end
  end

endmodule // asr_pin_sync

// >>> rtl/asr_code_check.sv
// Checks one input mux code against the channel count of the variant
`timescale 1ns/100ps
`include "asr_regs.svh"
module asr_code_check #(
  parameter int CHANNELS = 12
) (
  input  wire logic [3:0] code,
  output logic            code_ok
);

  localparam logic [3:0] LAST_AIN = (CHANNELS == `ASR_CHANNELS_SHORT) ? `ASR_CODE_LAST_SHORT : `ASR_CODE_LAST_LONG;

  initial begin
    if (CHANNELS != `ASR_CHANNELS_SHORT && CHANNELS != `ASR_CHANNELS_LONG) begin
      $error("asr_code_check: CHANNELS must be 6 or 12");
    end
  end

  // Reserved codes above the common input are never valid
  always_comb begin
    code_ok = (code <= LAST_AIN) || (code == `ASR_CODE_COMMON);
  end

endmodule // asr_code_check

// >>> rtl/asr_status_mux_regs.sv
// Status and input mux registers of the converter, reached by register read and write commands
//
// Operation
// - Power-on flag sets at every reset and clears only when host writes zero.
// - Bit 6 reads one while device still starts up, zero once ready.
// - Bits 5 and 4 flag positive amplifier output near upper or lower rail.
// - Bits 3 and 2 flag negative amplifier output near upper or lower rail.
// - Rail flags update only while the rail monitor enable is set.
// - Bit 1 flags reference below one third of the analog supply span.
// - Bit 0 flags reference below the low threshold, missing or floating.
// - Reference flags are driven only while the reference monitor enable allows.
// - Upper nibble selects positive input; twelve inputs, common, reserved; resets to zero.
// - Lower nibble selects negative input with same codes; resets to input one.
// - Codes for inputs six to eleven are only valid on twelve-channel parts.
// - Registers are read and written by register read and write commands.
`timescale 1ns/100ps
`include "asr_regs.svh"
module asr_status_mux_regs #(
  parameter int CHANNELS = 12
) (
  input  wire logic                 SYS_CLK,
  input  wire logic                 RST,
  input  wire asr_pkg::asr_cmd_t    CMD,
  input  wire asr_pkg::asr_monitor_t MON,
  input  wire logic                 RAIL_MONITOR_ENABLE,
  input  wire logic [1:0]           REF_MONITOR_ENABLE,
  output logic                      RSP_VALID,
  output logic                      RSP_HIT,
  output logic [7:0]                RSP_DATA,
  output logic [3:0]                POSITIVE_INPUT_SELECT,
  output logic [3:0]                NEGATIVE_INPUT_SELECT,
  output logic                      INPUT_CODE_FAULT
);
  import asr_pkg::*;

  // Register images
  asr_status_t  status;
  asr_status_t  next_status;
  asr_inmux_t   inmux;
  asr_inmux_t   next_inmux;

  // Read response
  logic         next_rsp_valid;
  logic         next_rsp_hit;
  logic [7:0]   next_rsp_data;

  // Mux outputs toward the analog switch matrix
  logic [3:0]   next_pos_sel;
  logic [3:0]   next_neg_sel;
  logic         next_code_fault;

  // Synchronised monitor levels
  asr_monitor_t mon_sync;
  logic         pos_code_ok;
  logic         neg_code_ok;

  // Decoded command strobes
  logic         wr_status;
  logic         wr_inmux;
  logic         rd_any;
  logic         ref_enabled;

  initial begin
    if (CHANNELS != `ASR_CHANNELS_SHORT && CHANNELS != `ASR_CHANNELS_LONG) begin
      $error("asr_status_mux_regs: CHANNELS must be 6 or 12");
    end
  end

  // Address decode of one command word
  function automatic logic addr_is(input logic [4:0] addr, input logic [4:0] target);
    addr_is = (addr == target);
  endfunction

  // Comparator levels come from the analog side and cross into this clock here
  asr_pin_sync #(
    .WIDTH    (7)
  ) u_mon_sync (
    .clk      (SYS_CLK),
    .rst      (RST),
    .async_in (MON),
    .sync_out (mon_sync)
  );

  // Validity of each selector against the variant
  asr_code_check #(
    .CHANNELS (CHANNELS)
  ) u_pos_check (
    .code     (inmux.positive_input_select),
    .code_ok  (pos_code_ok)
  );

  asr_code_check #(
    .CHANNELS (CHANNELS)
  ) u_neg_check (
    .code     (inmux.negative_input_select),
    .code_ok  (neg_code_ok)
  );

  // Command strobes; a command to another address is left to the other register blocks
  always_comb begin
    wr_status   = CMD.valid && CMD.write && addr_is(CMD.addr, `ASR_ADDR_STATUS);
    wr_inmux    = CMD.valid && CMD.write && addr_is(CMD.addr, `ASR_ADDR_INMUX);
    rd_any      = CMD.valid && !CMD.write;
    ref_enabled = (REF_MONITOR_ENABLE != 2'h0);
  end

  // Status next values
  always_comb begin
    next_status = status;
    // Only a written zero clears the flag; a written one leaves it as it is
    if (wr_status && !CMD.wdata[`ASR_BIT_POWER_ON]) begin
      next_status.power_on_flag = 1'b0;
    end
    // Live startup indication, never stored from a write
    next_status.not_ready = mon_sync.startup_busy;
    // Rail flags freeze while the monitor is off, so the last reading survives
    if (RAIL_MONITOR_ENABLE) begin
      next_status.pos_out_near_upper_rail = mon_sync.pos_upper;
      next_status.pos_out_near_lower_rail = mon_sync.pos_lower;
      next_status.neg_out_near_upper_rail = mon_sync.neg_upper;
      next_status.neg_out_near_lower_rail = mon_sync.neg_lower;
    end
    // Reference flags read zero while disabled, a dead reference is then not reported
    next_status.ref_below_third_supply  = ref_enabled && mon_sync.ref_third;
    next_status.ref_below_low_threshold = ref_enabled && mon_sync.ref_low;
  end

  // Status register; reset stands for power-on, so the flag comes up set
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      status <= asr_status_t'(`ASR_STATUS_RST);
    end else begin
      status <= next_status;
    end
  end

  // Input mux next values; reserved codes are stored as written and handled only at the selector outputs
  always_comb begin
    next_inmux = inmux;
    if (wr_inmux) begin
      next_inmux.positive_input_select = CMD.wdata[`ASR_POS_MSB:`ASR_POS_LSB];
      next_inmux.negative_input_select = CMD.wdata[`ASR_NEG_MSB:`ASR_NEG_LSB];
    end
  end

  // Input mux register
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      inmux <= asr_inmux_t'(`ASR_INMUX_RST);
    end else begin
      inmux <= next_inmux;
    end
  end

  // Selector outputs; an invalid code parks the switch on the common input
  always_comb begin
    next_code_fault = !(pos_code_ok && neg_code_ok);
    next_pos_sel    = pos_code_ok ? inmux.positive_input_select : `ASR_CODE_COMMON;
    next_neg_sel    = neg_code_ok ? inmux.negative_input_select : `ASR_CODE_COMMON;
  end

  // Selector output registers
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      POSITIVE_INPUT_SELECT <= `ASR_POS_SEL_RST;
      NEGATIVE_INPUT_SELECT <= `ASR_NEG_SEL_RST;
      INPUT_CODE_FAULT      <= 1'b0;
    end else begin
      POSITIVE_INPUT_SELECT <= next_pos_sel;
      NEGATIVE_INPUT_SELECT <= next_neg_sel;
      INPUT_CODE_FAULT      <= next_code_fault;
    end
  end

  // Read answer; data holds until the next read so a slow shifter can take it late
  always_comb begin
    next_rsp_valid = rd_any;
    next_rsp_hit   = RSP_HIT;
    next_rsp_data  = RSP_DATA;
    if (rd_any) begin
      if (addr_is(CMD.addr, `ASR_ADDR_STATUS)) begin
        next_rsp_hit  = 1'b1;
        next_rsp_data = status;
      end else if (addr_is(CMD.addr, `ASR_ADDR_INMUX)) begin
        next_rsp_hit  = 1'b1;
        next_rsp_data = inmux;
      end else begin
        next_rsp_hit  = 1'b0;
        next_rsp_data = 8'h00;
      end
    end
  end

  // Read answer registers
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      RSP_VALID <= 1'b0;
      RSP_HIT   <= 1'b0;
      RSP_DATA  <= 8'h00;
    end else begin
      RSP_VALID <= next_rsp_valid;
      RSP_HIT   <= next_rsp_hit;
      RSP_DATA  <= next_rsp_data;
    end
  end

endmodule // asr_status_mux_regs

// >>> test/asr_status_mux_regs_assertions.sv
// Concurrent checks on the ports of the status and input mux register block
`timescale 1ns/100ps
module asr_status_mux_regs_chk #(
  parameter int CHANNELS = 12
) (
  input wire logic                  SYS_CLK,
  input wire logic                  RST,
  input wire asr_pkg::asr_cmd_t     CMD,
  input wire asr_pkg::asr_monitor_t MON,
  input wire logic                  RAIL_MONITOR_ENABLE,
  input wire logic [1:0]            REF_MONITOR_ENABLE,
  input wire logic                  RSP_VALID,
  input wire logic                  RSP_HIT,
  input wire logic [7:0]            RSP_DATA,
  input wire logic [3:0]            POSITIVE_INPUT_SELECT,
  input wire logic [3:0]            NEGATIVE_INPUT_SELECT,
  input wire logic                  INPUT_CODE_FAULT
);
  import asr_pkg::*;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // Decoded command kinds
  logic rd;
  logic wr2;
  assign rd  = CMD.valid && !CMD.write;
  assign wr2 = CMD.valid && CMD.write && CMD.addr == 5'h02;
  // Reserved codes and inputs missing on a short part fall back to the common input
  function automatic logic [3:0] sel(input logic [3:0] c);
    return (c < 4'(CHANNELS) || c == 4'hC) ? c : 4'hC;
  endfunction
  property p_read_answer;
    rd |=> RSP_VALID;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read got no answer");
  property p_miss;
    rd && CMD.addr != 5'h01 && CMD.addr != 5'h02 |=> !RSP_HIT && RSP_DATA == 8'h00;
  endproperty
  a_miss: assert property (p_miss) else $error("unmapped read gave a hit");
  property p_inmux_back;
    wr2 ##1 !CMD.valid ##1 (rd && CMD.addr == 5'h02) |=> RSP_DATA == $past(CMD.wdata, 3);
  endproperty
  a_inmux_back: assert property (p_inmux_back) else $error("mux readback wrong");
  property p_reset_sel;
    $fell(RST) |-> POSITIVE_INPUT_SELECT == 4'h0 && NEGATIVE_INPUT_SELECT == 4'h1 && !INPUT_CODE_FAULT;
  endproperty
  a_reset_sel: assert property (p_reset_sel) else $error("selectors wrong after reset");
  property p_select;
    wr2 |-> ##2 {POSITIVE_INPUT_SELECT, NEGATIVE_INPUT_SELECT} ==
      {sel($past(CMD.wdata[7:4], 2)), sel($past(CMD.wdata[3:0], 2))};
  endproperty
  a_select: assert property (p_select) else $error("selector output wrong");
  property p_fault;
    wr2 |-> ##2 INPUT_CODE_FAULT == ({sel($past(CMD.wdata[7:4], 2)), sel($past(CMD.wdata[3:0], 2))}
      != $past(CMD.wdata, 2));
  endproperty
  a_fault: assert property (p_fault) else $error("code fault wrong");
  property p_monitors;
    ($stable(MON) && RAIL_MONITOR_ENABLE && REF_MONITOR_ENABLE != 2'b00)[*7] ##0 (rd && CMD.addr == 5'h01)
      |=> RSP_DATA[6:0] == $past(MON);
  endproperty
  a_monitors: assert property (p_monitors) else $error("status flags off");
  property p_ref_off;
    (REF_MONITOR_ENABLE == 2'b00)[*3] ##0 (rd && CMD.addr == 5'h01) |=> RSP_DATA[1:0] == 2'b00;
  endproperty
  a_ref_off: assert property (p_ref_off) else $error("ref flag while disabled");
endmodule // asr_status_mux_regs_chk

bind asr_status_mux_regs asr_status_mux_regs_chk #(.CHANNELS(CHANNELS)) i_asr_status_mux_regs_chk (
  .SYS_CLK(SYS_CLK), .RST(RST), .CMD(CMD), .MON(MON), .RAIL_MONITOR_ENABLE(RAIL_MONITOR_ENABLE),
  .REF_MONITOR_ENABLE(REF_MONITOR_ENABLE), .RSP_VALID(RSP_VALID), .RSP_HIT(RSP_HIT), .RSP_DATA(RSP_DATA),
  .POSITIVE_INPUT_SELECT(POSITIVE_INPUT_SELECT), .NEGATIVE_INPUT_SELECT(NEGATIVE_INPUT_SELECT),
  .INPUT_CODE_FAULT(INPUT_CODE_FAULT));

// >>> test/asr_host_model.sv
// Host side model that issues register commands and collects the answers
`timescale 1ns/100ps
module asr_host_model (
  input  wire logic        clk,
  input  wire logic        rsp_valid,
  input  wire logic        rsp_hit,
  input  wire logic [7:0]  rsp_data,
  output asr_pkg::asr_cmd_t cmd
);
  import asr_pkg::*;
  initial cmd = '0;
  // One command held to its taking edge; idle fields flip so stale values never look valid
  task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d,
                      output logic v, output logic h, output logic [7:0] q);
    @(posedge clk);
    #1 cmd = '{1'b1, w, a, d};
    @(posedge clk);
    #1 v = rsp_valid;
    h = rsp_hit;
    q = rsp_data;
    cmd = '{1'b0, w, ~a, ~d};
  endtask
endmodule // asr_host_model

// >>> test/tb_asr_status_mux_regs.sv
// Self-checking bench of the status and input mux register block
`timescale 1ns/100ps
module tb_asr_status_mux_regs;
  import asr_pkg::*;
  logic         sys_clk = 1'b0;
  logic         rst = 1'b1;
  asr_cmd_t     cmd;
  asr_monitor_t mon = '0;
  logic         rail_en = 1'b0;
  logic [1:0]   ref_en = 2'b00;
  logic         rsp_valid, rsp_hit, fault, v, h;
  logic [7:0]   rsp_data, q, d;
  logic [3:0]   pos_sel, neg_sel;
  logic [3:0]   pos_six, neg_six;
  logic         fault_six;
  int           n_fail = 0, n_checks = 0, cycles = 0, seed = 31193;
  localparam logic [7:0] CORNER [4] = '{8'hCB, 8'hDE, 8'h6F, 8'h00};

  asr_status_mux_regs #(.CHANNELS(12)) i_asr_status_mux_regs (.SYS_CLK(sys_clk), .RST(rst), .CMD(cmd),
    .MON(mon), .RAIL_MONITOR_ENABLE(rail_en), .REF_MONITOR_ENABLE(ref_en), .RSP_VALID(rsp_valid),
    .RSP_HIT(rsp_hit), .RSP_DATA(rsp_data), .POSITIVE_INPUT_SELECT(pos_sel),
    .NEGATIVE_INPUT_SELECT(neg_sel), .INPUT_CODE_FAULT(fault));
  asr_host_model i_asr_host_model (.clk(sys_clk), .rsp_valid(rsp_valid), .rsp_hit(rsp_hit),
    .rsp_data(rsp_data), .cmd(cmd));
  // Six-input variant on the same command stream, so the short code table is exercised too
  asr_status_mux_regs #(.CHANNELS(6)) i_asr_status_mux_regs_six (.SYS_CLK(sys_clk), .RST(rst), .CMD(cmd),
    .MON(mon), .RAIL_MONITOR_ENABLE(rail_en), .REF_MONITOR_ENABLE(ref_en), .RSP_VALID(), .RSP_HIT(),
    .RSP_DATA(), .POSITIVE_INPUT_SELECT(pos_six), .NEGATIVE_INPUT_SELECT(neg_six), .INPUT_CODE_FAULT(fault_six));

  // Clock and a hang guard well above the few hundred cycles the run needs
  initial forever #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      conclude();
    end
  end

  // Selector a code should drive on a part whose last analog input code is last
  function automatic logic [3:0] sel_of(input logic [3:0] c, input logic [3:0] last);
    return (c <= last || c == 4'hC) ? c : 4'hC;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic hit);
    i_asr_host_model.xfer(1'b0, a, 8'h00, v, h, q);
    chk({7'h0, v}, 8'h01);
    chk({7'h0, h}, {7'h0, hit});
    chk(q, e);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] dd);
    i_asr_host_model.xfer(1'b1, a, dd, v, h, q);
    chk({7'h0, v}, 8'h00);
  endtask
  // Monitor levels need the synchroniser flush before a read can see them
  task automatic mon_set(input asr_monitor_t m, input logic r, input logic [1:0] f);
    @(posedge sys_clk);
    #1 mon = m;
    rail_en = r;
    ref_en = f;
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic conclude();
    if (n_fail == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    #1 rst = 1'b0;
    rd(5'h01, 8'h80, 1'b1);
    rd(5'h02, 8'h01, 1'b1);
    chk({pos_sel, neg_sel}, 8'h01);
    wr(5'h01, 8'hFF);
    rd(5'h01, 8'h80, 1'b1);
    wr(5'h01, 8'h7F);
    rd(5'h01, 8'h00, 1'b1);
    wr(5'h03, 8'hA5);
    rd(5'h03, 8'h00, 1'b0);
    rd(5'h1F, 8'h00, 1'b0);
    // Corner codes first, then random ones
    for (int i = 0; i < 40; i++) begin
      d = (i < 4) ? CORNER[i] : 8'($random(seed));
      wr(5'h02, d);
      rd(5'h02, d, 1'b1);
      chk({pos_sel, neg_sel}, {sel_of(d[7:4], 4'hB), sel_of(d[3:0], 4'hB)});
      chk({7'h0, fault}, {7'h0, {sel_of(d[7:4], 4'hB), sel_of(d[3:0], 4'hB)} != d});
      chk({pos_six, neg_six}, {sel_of(d[7:4], 4'h5), sel_of(d[3:0], 4'h5)});
      chk({7'h0, fault_six}, {7'h0, {sel_of(d[7:4], 4'h5), sel_of(d[3:0], 4'h5)} != d});
    end
    // Each monitor alone, every nonzero reference enable code
    for (int k = 0; k < 7; k++) begin
      mon_set(7'(1 << k), 1'b1, 2'(k % 3 + 1));
      rd(5'h01, 8'(1 << k), 1'b1);
    end
    mon_set(7'h7F, 1'b0, 2'b10);
    rd(5'h01, 8'h43, 1'b1);
    mon_set(7'h7F, 1'b0, 2'b00);
    rd(5'h01, 8'h40, 1'b1);
    mon_set(7'h7F, 1'b1, 2'b00);
    rd(5'h01, 8'h7C, 1'b1);
    // Second reset in mid-run brings the flag and the mux defaults back
    mon_set('0, 1'b1, 2'b01);
    #1 rst = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 rst = 1'b0;
    rd(5'h01, 8'h80, 1'b1);
    rd(5'h02, 8'h01, 1'b1);
    chk({pos_sel, neg_sel}, 8'h01);
    chk({pos_six, neg_six}, 8'h01);
    chk({6'h0, fault, fault_six}, 8'h00);
    conclude();
  end
endmodule // tb_asr_status_mux_regs
